// ---- design/pcq_regs.svh ----
`ifndef PCQ_REGS_SVH
`define PCQ_REGS_SVH

// ==========================================================
// Register map
`define PCQ_ADDR_PAGE 6'h00
`define PCQ_ADDR_CMD 6'h01
`define PCQ_ADDR_QUEUE 6'h02
`define PCQ_PAGE_LOW 3'h0

// ==========================================================
// Page register fields
`define PCQ_PAGE_RST 8'h80
`define PCQ_PAGE_MASK 8'h87
`define PCQ_PAGE_EN_BIT 7

// ==========================================================
// Command register fields
`define PCQ_CMD_RST 6'h00
`define PCQ_CMD_DETECT_BIT 7

// ==========================================================
// Queue geometry
`define PCQ_QUEUE_FULL 7'h40
`define PCQ_COUNT_ZERO 7'h00
`define PCQ_COUNT_ONE 7'h01
`define PCQ_PTR_ONE 6'h01
`define PCQ_SKID_FULL 2'h2
`define PCQ_SKID_ZERO 2'h0
`define PCQ_SKID_ONE 2'h1
`define PCQ_BYTE_ZERO 8'h00

`endif

// ---- design/pcq_pkg.sv ----
// ==========================================================
// Shared types
package pcq_pkg;

  // Host register access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] pin_addr;
    logic [5:0] latch_addr;
    logic low_from_pins;
    logic [7:0] wdata;
  } pcq_host_req_t;

  // Host read answer
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } pcq_host_rsp_t;

  // Byte stream beat
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pcq_beat_t;

endpackage : pcq_pkg

// ---- design/pcq_regs_top.sv ----
// Notes on behaviour
// R1: Page register mirrored at every multiple of eight
// R2: Page register resets to 0x80
// R3: Paged mode: page forms address bits 5..3
// R4: Unpaged mode: latch gives whole address
// R5: Command bit 7 shows detection busy
// R6: Writing command field starts that command
// R7: Command read returns executing command code
// R8: Command bits 6..0 clear after reset
// R9: Queue port writes push, reads pop
// R10: Queue carries whole bytes in and out
// R11: Fill count follows pushes and pops
// R12: Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "pcq_regs.svh"

module pcq_regs_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host register port
  input wire pcq_pkg::pcq_host_req_t host_req,
  output pcq_pkg::pcq_host_rsp_t host_rsp,
  // Command engine side
  input wire logic host_port_detect_busy,
  input wire logic cmd_done,
  output logic cmd_start,
  output logic [5:0] cmd_code,
  // Page state
  output logic paged_addressing_on,
  output logic [2:0] page_number,
  // Core bytes into the queue
  input wire pcq_pkg::pcq_beat_t core_in,
  output logic core_in_ready,
  // Queue bytes out to the core
  output pcq_pkg::pcq_beat_t core_out,
  input wire logic core_out_ready,
  // Queue level
  output logic [6:0] queue_fill_count
);

  // ==========================================================
  // Helpers

  // Register address from page state and host address sources
  function automatic logic [5:0] form_addr(input logic paged, input logic [2:0] page,
                                           input pcq_pkg::pcq_host_req_t req);
    logic [2:0] low;
    low = req.low_from_pins ? req.pin_addr : req.latch_addr[2:0];
    form_addr = paged ? {page, low} : req.latch_addr; // [R3] [R4]
  endfunction : form_addr

  // Queue pointer step with wrap at depth
  function automatic logic [5:0] ptr_step(input logic [5:0] ptr);
    ptr_step = ptr + `PCQ_PTR_ONE;
  endfunction : ptr_step

  // ==========================================================
  // State

  logic [7:0] page; // Page register contents
  logic [7:0] qmem [64]; // Queue storage, one byte per entry
  logic [5:0] q_wptr; // Queue write pointer
  logic [5:0] q_rptr; // Queue read pointer
  logic [7:0] skid [2]; // Two-entry output buffer
  logic skid_wptr; // Buffer write slot
  logic skid_rptr; // Buffer read slot
  logic [1:0] skid_cnt; // Buffer occupancy

  // ==========================================================
  // Address decode

  wire [5:0] reg_addr = form_addr(paged_addressing_on, page_number, host_req);
  wire host_wr = host_req.valid && host_req.write;
  wire host_rd = host_req.valid && !host_req.write;
  wire hit_page = (reg_addr[2:0] == `PCQ_PAGE_LOW); // [R1]
  wire hit_cmd = (reg_addr == `PCQ_ADDR_CMD);
  wire hit_queue = (reg_addr == `PCQ_ADDR_QUEUE);

  // ==========================================================
  // Queue control

  wire q_full = (queue_fill_count == `PCQ_QUEUE_FULL);
  wire q_empty = (queue_fill_count == `PCQ_COUNT_ZERO);
  wire host_push = host_wr && hit_queue && !q_full; // [R9]
  wire host_pop = host_rd && hit_queue && !q_empty; // [R9]
  wire host_q_busy = host_req.valid && hit_queue;
  wire skid_in_ready = (skid_cnt != `PCQ_SKID_FULL);
  wire skid_out_take = core_out.valid && core_out_ready;
  assign core_in_ready = !q_full && !host_q_busy;
  wire core_push = core_in.valid && core_in_ready;
  wire drain_pop = !q_empty && !host_q_busy && skid_in_ready;
  wire do_push = host_push || core_push;
  wire do_pop = host_pop || drain_pop;
  wire [7:0] push_byte = host_push ? host_req.wdata : core_in.data; // [R10]
  wire [6:0] next_fill = queue_fill_count + {6'h00, do_push} - {6'h00, do_pop};

  // ==========================================================
  // Answer data selection

  wire [7:0] cmd_view = {host_port_detect_busy, 1'b0, cmd_code}; // [R5] [R7] [R12]
  wire [7:0] pop_byte = q_empty ? `PCQ_BYTE_ZERO : qmem[q_rptr];
  wire [7:0] next_rdata = hit_page ? page : hit_cmd ? cmd_view : hit_queue ? pop_byte
                          : `PCQ_BYTE_ZERO;

  assign paged_addressing_on = page[`PCQ_PAGE_EN_BIT];
  assign page_number = page[2:0];

  // ==========================================================
  // Page register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      page <= `PCQ_PAGE_RST; // [R2]
    else if (host_wr && hit_page)
      page <= host_req.wdata & `PCQ_PAGE_MASK; // [R1] [R12]
  end

  // ==========================================================
  // Command register and start pulse
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cmd_code <= `PCQ_CMD_RST; // [R8]
      cmd_start <= 1'b0;
    end
    else
    begin
      // Host write beats completion in the same cycle
      cmd_start <= host_wr && hit_cmd; // [R6]
      if (host_wr && hit_cmd)
        cmd_code <= host_req.wdata[5:0]; // [R6] [R12]
      else if (cmd_done)
        cmd_code <= `PCQ_CMD_RST; // [R7]
    end
  end

  // ==========================================================
  // Host read answer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      host_rsp <= '0;
    else
    begin
      host_rsp.valid <= host_rd;
      host_rsp.rdata <= host_rd ? next_rdata : `PCQ_BYTE_ZERO;
    end
  end

  // ==========================================================
  // Queue storage write
  always_ff @(posedge clk)
  begin
    if (do_push)
      qmem[q_wptr] <= push_byte; // [R10]
  end

  // ==========================================================
  // Queue pointers and fill count
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q_wptr <= '0;
      q_rptr <= '0;
      queue_fill_count <= `PCQ_COUNT_ZERO;
    end
    else
    begin
      if (do_push)
        q_wptr <= ptr_step(q_wptr);
      if (do_pop)
        q_rptr <= ptr_step(q_rptr);
      queue_fill_count <= next_fill; // [R11]
    end
  end

  // ==========================================================
  // Output buffer storage
  always_ff @(posedge clk)
  begin
    if (drain_pop)
      skid[skid_wptr] <= qmem[q_rptr];
  end

  // ==========================================================
  // Output buffer control
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      skid_wptr <= 1'b0;
      skid_rptr <= 1'b0;
      skid_cnt <= `PCQ_SKID_ZERO;
    end
    else
    begin
      if (drain_pop)
        skid_wptr <= !skid_wptr;
      if (skid_out_take)
        skid_rptr <= !skid_rptr;
      skid_cnt <= skid_cnt + {1'b0, drain_pop} - {1'b0, skid_out_take};
    end
  end

  // Buffer head to the core, driven as one struct
  wire head_valid = (skid_cnt != `PCQ_SKID_ZERO); // Buffer holds a byte
  wire [7:0] head_byte = skid[skid_rptr]; // Oldest buffered byte
  assign core_out = {head_valid, head_byte}; // [R10]

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Page register value after reset
  page_reset_a: assert property (@(posedge clk) disable iff (1'b0) // [R2]
    !rst_b |=> page == `PCQ_PAGE_RST)
    else $error("page register not 0x80 after reset");

  // Command field clear after reset
  cmd_reset_a: assert property (@(posedge clk) disable iff (1'b0) // [R8]
    !rst_b |=> cmd_code == `PCQ_CMD_RST && !cmd_start)
    else $error("command field not cleared after reset");

  // Page write through any mirror
  page_mirror_a: assert property ( // [R1]
    host_wr && reg_addr[2:0] == `PCQ_PAGE_LOW
    |=> page == ($past(host_req.wdata) & `PCQ_PAGE_MASK) && page[6:3] == 4'h0)
    else $error("page mirror write not stored");

  // Paged address formation
  paged_addr_a: assert property ( // [R3]
    paged_addressing_on |-> reg_addr[5:3] == page[2:0]
    && reg_addr[2:0] == (host_req.low_from_pins ? host_req.pin_addr
                         : host_req.latch_addr[2:0]))
    else $error("paged address wrong");

  // Latched address formation
  latch_addr_a: assert property ( // [R4]
    !paged_addressing_on |-> reg_addr == host_req.latch_addr)
    else $error("latched address wrong");

  // Detection bit on command read
  detect_bit_a: assert property ( // [R5]
    host_rd && hit_cmd |=> host_rsp.valid
    && host_rsp.rdata[`PCQ_CMD_DETECT_BIT] == $past(host_port_detect_busy))
    else $error("detect busy bit wrong");

  // Command start follows write
  cmd_start_a: assert property ( // [R6]
    host_wr && hit_cmd |=> cmd_start && cmd_code == $past(host_req.wdata[5:0])
    ##1 !cmd_start || $past(host_wr && hit_cmd))
    else $error("command not started with written code");

  // Command read shows running code
  cmd_read_a: assert property ( // [R7]
    host_rd && hit_cmd |=> host_rsp.rdata[6:0] == {1'b0, $past(cmd_code)})
    else $error("command read wrong");

  // Host push grows the count
  fill_push_a: assert property ( // [R11]
    host_push |=> queue_fill_count == $past(queue_fill_count) + `PCQ_COUNT_ONE)
    else $error("fill count not incremented");

  // Host pop shrinks the count and returns the head
  fill_pop_a: assert property ( // [R9]
    host_pop |=> queue_fill_count == $past(queue_fill_count) - `PCQ_COUNT_ONE
    && host_rsp.rdata == $past(qmem[q_rptr]))
    else $error("queue pop wrong");

  // Buffer never over full
  skid_bound_a: assert property ( // [R10]
    skid_cnt != 2'h3 && queue_fill_count <= `PCQ_QUEUE_FULL)
    else $error("buffer level out of range");

  // Command field cleared when the command ends
  cmd_done_a: assert property ( // [R7]
    cmd_done && !(host_wr && hit_cmd) |=> cmd_code == `PCQ_CMD_RST)
    else $error("command field not cleared at completion");

  // Reserved page bits read as zero
  page_resv_a: assert property ( // [R12]
    host_rd && hit_page |=> (host_rsp.rdata & ~`PCQ_PAGE_MASK) == `PCQ_BYTE_ZERO)
    else $error("reserved page bits not zero");

  // Write to a full queue is dropped
  full_drop_a: assert property ( // [R9]
    host_wr && hit_queue && q_full |=> queue_fill_count == $past(queue_fill_count))
    else $error("full queue accepted a byte");

  // Drain into the buffer shrinks the count
  fill_drain_a: assert property ( // [R11]
    drain_pop && !core_push |=> queue_fill_count == $past(queue_fill_count) - `PCQ_COUNT_ONE)
    else $error("fill count not decremented by drain");

  // Answer only after a read, zero otherwise
  rsp_idle_a: assert property ( // [R9]
    !host_rd |=> !host_rsp.valid && host_rsp.rdata == `PCQ_BYTE_ZERO)
    else $error("answer without a read");

  // Main scenarios
  page_write_c: cover property (host_wr && hit_page ##1 !paged_addressing_on);
  cmd_run_c: cover property (cmd_start ##[1:20] cmd_done);
  queue_full_c: cover property (q_full ##1 host_pop);
  stall_c: cover property (skid_cnt == `PCQ_SKID_FULL && !core_out_ready);
  cmd_clash_c: cover property (cmd_done && host_wr && hit_cmd);

endmodule : pcq_regs_top

`default_nettype wire

// ---- testbench/pcq_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Core-side sink of the byte stream
module pcq_core_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Stream from the block
  input wire logic stall,
  input wire pcq_pkg::pcq_beat_t core_out,
  output logic core_out_ready,
  // Tally of bytes taken
  output logic [7:0] got_cnt,
  output logic [7:0] got_last
);
  // Ready only while not stalled
  assign core_out_ready = !stall;
  // Count each whole byte taken and keep the last one
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      got_cnt <= 8'h00;
      got_last <= 8'h00;
    end
    else if (core_out.valid && core_out_ready)
    begin
      got_cnt <= got_cnt + 8'h01;
      got_last <= core_out.data;
    end
  end
endmodule : pcq_core_model
`default_nettype wire

// ---- testbench/tb_pcq_regs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pcq_regs_top;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pcq_pkg::pcq_host_req_t req = '0;
  pcq_pkg::pcq_host_rsp_t rsp;
  logic busy = 1'b1;
  logic done = 1'b0;
  logic start;
  logic [5:0] code;
  logic pon;
  logic [2:0] pnum;
  pcq_pkg::pcq_beat_t cin = '0;
  logic cin_rdy;
  pcq_pkg::pcq_beat_t cout;
  logic cout_rdy;
  logic [6:0] fill;
  logic stall = 1'b1;
  logic [7:0] got_cnt;
  logic [7:0] got_last;
  logic [7:0] rd;
  logic rdv;
  int error_cnt = 0;
  int cmp_count = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // ==========================================
  // Block and core model
  pcq_regs_top i_pcq_regs_top (.clk(clk), .rst_b(rst_b), .host_req(req), .host_rsp(rsp),
    .host_port_detect_busy(busy), .cmd_done(done), .cmd_start(start), .cmd_code(code),
    .paged_addressing_on(pon), .page_number(pnum), .core_in(cin), .core_in_ready(cin_rdy),
    .core_out(cout), .core_out_ready(cout_rdy), .queue_fill_count(fill));
  pcq_core_model i_pcq_core_model (.clk(clk), .rst_b(rst_b), .stall(stall), .core_out(cout),
    .core_out_ready(cout_rdy), .got_cnt(got_cnt), .got_last(got_last));
  // ==========================================
  // Tasks
  // Byte compare
  task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  // One host access, answer taken one edge later
  task acc(input logic wr, input logic [2:0] pin, input logic [5:0] lat, input logic lfp,
    input logic [7:0] wd);
    @(posedge clk);
    #1;
    req = {1'b1, wr, pin, lat, lfp, wd};
    @(posedge clk);
    #1;
    rd = rsp.rdata;
    rdv = rsp.valid;
    req.valid = 1'b0;
  endtask : acc
  // Paged access, low bits from pins
  task rdp(input logic [2:0] pin);
    acc(1'b0, pin, 6'h00, 1'b1, 8'h00);
  endtask : rdp
  task wrp(input logic [2:0] pin, input logic [7:0] d);
    acc(1'b1, pin, 6'h00, 1'b1, d);
  endtask : wrp
  // Core byte into the queue, held until taken or dropped after eight cycles without ready
  task cpush(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cin = {1'b1, d};
    while (!cin_rdy && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk8("in_ready", 8'h01, {7'h00, cin_rdy});
    @(posedge clk);
    #1;
    cin.valid = 1'b0;
  endtask : cpush
  // Verdict and end of run
  task print_verdict();
    if (error_cnt == 0 && cmp_count > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // Watchdog, far beyond the expected run
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  // ==========================================
  // Tests
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // Reset values and detect bit
    rdp(3'h0);
    chk8("page", 8'h80, rd);
    rdp(3'h1);
    chk8("cmd", 8'h80, rd);
    chk8("rsp_valid", 8'h01, {7'h00, rdv});
    busy = 1'b0;
    rdp(3'h1);
    chk8("cmd", 8'h00, rd);
    // Reserved page bits
    wrp(3'h0, 8'hF8);
    chk8("rsp_valid", 8'h00, {7'h00, rdv});
    rdp(3'h0);
    chk8("page", 8'h80, rd);
    // Paged mode on page 5
    wrp(3'h0, 8'h85);
    chk8("page_number", 8'h05, {5'h00, pnum});
    rdp(3'h0);
    chk8("page", 8'h85, rd);
    rdp(3'h1);
    chk8("unmapped", 8'h00, rd);
    acc(1'b0, 3'h7, 6'h00, 1'b0, 8'h00);
    chk8("page", 8'h85, rd);
    wrp(3'h0, 8'h80);
    // Unpaged mode, page number ignored
    wrp(3'h0, 8'h05);
    chk8("paged_on", 8'h00, {7'h00, pon});
    acc(1'b0, 3'h0, 6'h38, 1'b1, 8'h00);
    chk8("page", 8'h05, rd);
    acc(1'b0, 3'h0, 6'h01, 1'b1, 8'h00);
    chk8("cmd", 8'h00, rd);
    acc(1'b1, 3'h0, 6'h00, 1'b0, 8'h80);
    // Command start, readback and end
    wrp(3'h1, 8'hFF);
    chk8("start", 8'h01, {7'h00, start});
    chk8("code", 8'h3F, {2'h0, code});
    @(posedge clk);
    #1;
    chk8("start", 8'h00, {7'h00, start});
    rdp(3'h1);
    chk8("cmd", 8'h3F, rd);
    done = 1'b1;
    @(posedge clk);
    #1;
    done = 1'b0;
    rdp(3'h1);
    chk8("cmd", 8'h00, rd);
    // Host push and pop with core stalled
    wrp(3'h2, 8'h11);
    wrp(3'h2, 8'h22);
    wrp(3'h2, 8'h33);
    wrp(3'h2, 8'h44);
    repeat (4) @(posedge clk);
    #1;
    chk8("fill", 8'h02, {1'b0, fill});
    rdp(3'h2);
    chk8("pop", 8'h33, rd);
    chk8("fill", 8'h01, {1'b0, fill});
    rdp(3'h2);
    chk8("pop", 8'h44, rd);
    rdp(3'h2);
    chk8("empty", 8'h00, rd);
    chk8("fill", 8'h00, {1'b0, fill});
    stall = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk8("got_cnt", 8'h02, got_cnt);
    chk8("got_last", 8'h22, got_last);
    // Fill to 64 plus buffer, then drain
    stall = 1'b1;
    for (int i = 0; i < 66; i++)
      cpush(8'(i));
    repeat (4) @(posedge clk);
    #1;
    chk8("fill", 8'h40, {1'b0, fill});
    chk8("in_ready", 8'h00, {7'h00, cin_rdy});
    wrp(3'h2, 8'hEE);
    chk8("fill", 8'h40, {1'b0, fill});
    stall = 1'b0;
    repeat (80) @(posedge clk);
    #1;
    chk8("fill", 8'h00, {1'b0, fill});
    chk8("got_cnt", 8'h44, got_cnt);
    chk8("got_last", 8'h41, got_last);
    // Mid-run reset restores page and command
    wrp(3'h1, 8'h15);
    wrp(3'h0, 8'h83);
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk8("page", 8'h80, {pon, 4'h0, pnum});
    chk8("code", 8'h00, {2'h0, code});
    chk8("fill", 8'h00, {1'b0, fill});
    rdp(3'h0);
    chk8("page", 8'h80, rd);
    rdp(3'h1);
    chk8("cmd", 8'h00, rd);
    print_verdict();
  end
endmodule : tb_pcq_regs_top
`default_nettype wire
